// File: rtl/touch_acquisition_mode_sequencer.sv
// touch acquisition sequencer: modes, commands, pen detection, timing
`include "tacq_consts.svh"

// Functional notes
// - three modes: host driven, watch, triggered
// - reset leaves device in host driven mode
// - host driven mode acts only on commands
// - host convert runs pen detection first
// - host driven mode never changes touch flag
// - convert biases, waits bias delay, converts
// - select only biases a channel
// - sequence code converts every masked channel
// - conversion end lowers irq, reads release
// - conversion after select skips pen detection
// - watch mode only detects pen, no conversion
// - watch mode waits while irq is low
// - triggered mode converts masked channels on touch
// - triggered mode waits until data fully read
// - conversion time follows oscillator period formula
// - bias and settle delays 0.5us to 18.19ms; bias here up to 65536 units, settle 0 at filter 0, else up to 393216 units
// - channel mask selects one to five channels
// - touch sets flag, release clears, both interrupt
// - pen detection biases one eighth bias delay
module touch_acquisition_mode_sequencer #(
    parameter int CH_NUM = `CH_NUM,
    parameter int DATA_W = `DATA_W
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_osc_clk,
    input wire logic i_pen_cmp,
    input wire logic [DATA_W-1:0] i_adc_data,
    output logic [CH_NUM-1:0] o_bias_ch,
    output logic o_pen_bias,
    output logic o_converting,
    output logic o_irq_n,
    output tacq_pkg::mode_t o_mode
);
    import tacq_pkg::*;

    localparam int WAIT_W = 20;

    function automatic logic [2:0] oh_index(input logic [CH_NUM-1:0] oh);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 0; i < CH_NUM; i++) begin
            if (oh[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : oh_index

    mode_t mode_q;
    state_t state_q, state_d;
    logic [15:0] rate_q, bias_set_q, settle_set_q;
    logic [1:0] filt_q;
    logic [CH_NUM-1:0] chmask_q, job_q, cur_q, done_q, unread_q, bias_q;
    logic [3:0] imask_q;
    logic touch_src_q, release_src_q, pen_flag_q, busy_q, armed_q;
    logic pen_bias_q, irq_n_q, tick_q, use_osc_q, osc_prev_q;
    logic [WAIT_W-1:0] wait_q;
    logic [3:0] unit_cnt_q;
    logic [11:0] rate_pre_q;
    logic [15:0] rate_cnt_q;
    logic load_en, load_osc;
    logic [WAIT_W-1:0] load_val;

    // pins from outside the clock domain: three stages, change on agreement
    wire logic [1:0] pin_raw = {i_pen_cmp, i_osc_clk};
    wire logic [1:0] pin_lvl;
    genvar g;
    for (g = 0; g < 2; g++) begin : g_sync
        logic s1_q, s2_q, s3_q, lvl_q;
        always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
                s1_q <= 1'b0;
                s2_q <= 1'b0;
                s3_q <= 1'b0;
                lvl_q <= 1'b0;
            end else begin
                s1_q <= pin_raw[g];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q) begin
                    lvl_q <= s3_q;
                end
            end
        end
        assign pin_lvl[g] = lvl_q;
    end
    wire logic pen_lvl = pin_lvl[1];
    wire logic osc_edge = pin_lvl[0] & ~osc_prev_q;

    // command and register decode
    wire cmd_t cmd = i_wdata[7:0];
    wire logic cmd_wr = i_wr && i_addr == `OFF_CMD;
    wire logic is_seq = cmd.chan == `SEQ_CODE;
    wire logic chan_ok = 32'(cmd.chan) < CH_NUM;
    wire logic [CH_NUM-1:0] chan_oh =
        chan_ok ? CH_NUM'(1) << cmd.chan : '0;
    wire logic man_ok = state_q == ST_IDLE && mode_q == HOST_DRIVEN_MODE;
    wire logic sel_go = cmd_wr && cmd.op == OP_SELECT && man_ok
        && !is_seq && chan_ok;
    wire logic conv_go = cmd_wr && cmd.op == OP_CONVERT && man_ok
        && (is_seq ? |chmask_q : chan_ok);
    wire logic [CH_NUM-1:0] conv_mask =
        is_seq ? chmask_q : chan_oh;
    wire logic auto_ok = (mode_q == TOUCH_WATCH_MODE && irq_n_q)
        || (mode_q == TOUCH_TRIGGERED_MODE && unread_q == '0);
    wire logic auto_go = state_q == ST_IDLE && auto_ok
        && (!pen_flag_q || tick_q);
    wire logic start = state_q == ST_IDLE && (conv_go || auto_go);
    wire logic [CH_NUM-1:0] job_start = conv_go ? conv_mask
        : (mode_q == TOUCH_TRIGGERED_MODE ? chmask_q : '0);
    wire logic isrc_rd = i_rd && i_addr == `OFF_ISRC;
    wire logic data_hit = (i_addr & `CHDATA_MASK) == `OFF_CHDATA
        && 32'(i_addr[4:2]) < CH_NUM;
    wire logic [CH_NUM-1:0] data_rd_oh =
        (i_rd && data_hit) ? CH_NUM'(1) << i_addr[4:2] : '0;

    // delay lengths, in 0.5us units or oscillator periods
    wire logic [WAIT_W-1:0] bias_units =
        WAIT_W'(bias_set_q) + WAIT_W'(1);
    wire logic [WAIT_W-1:0] pen_raw = bias_units >> `PEN_BIAS_SHIFT;
    wire logic [WAIT_W-1:0] pen_units =
        (pen_raw == '0) ? WAIT_W'(1) : pen_raw;
    wire logic [WAIT_W-1:0] settle_units = WAIT_W'((WAIT_W'(settle_set_q)
        + WAIT_W'(1)) * WAIT_W'(filt_q) * WAIT_W'(2));
    wire logic [WAIT_W-1:0] sample_osc = WAIT_W'(`CONV_SAMPLE_OSC * 2)
        * WAIT_W'(filt_q) + WAIT_W'(`CONV_SAMPLE_OSC + 1);
    wire logic [WAIT_W-1:0] start_osc = WAIT_W'(`CONV_START_OSC);
    wire logic wait_zero = wait_q == '0;
    wire logic unit_tick = unit_cnt_q == 4'(`UNIT_CYC - 1);

    // channel stepping
    wire logic [CH_NUM-1:0] rest = job_q & ~cur_q;
    wire logic [CH_NUM-1:0] next_src =
        (state_q == ST_CH_CONV) ? rest : job_q;
    wire logic [CH_NUM-1:0] next_ch = next_src & (~next_src + 1'b1);
    wire logic enter_bias = state_d == ST_CH_BIAS && state_q != ST_CH_BIAS;
    wire logic ch_end = state_q == ST_CH_CONV && wait_zero;
    wire logic pen_upd = state_q == ST_PEN_EVAL
        && mode_q != HOST_DRIVEN_MODE;
    wire logic touch_set = pen_upd && pen_lvl && !pen_flag_q;
    wire logic release_set = pen_upd && !pen_lvl && pen_flag_q;
    wire irq_src_t isrc = '{release_ev: release_src_q,
        touch_ev: touch_src_q, spare: 1'b0, conv_done: |unread_q};
    wire logic rate_run = mode_q != HOST_DRIVEN_MODE && rate_q != '0;

    always_comb begin
        state_d = state_q;
        load_en = 1'b0;
        load_val = '0;
        load_osc = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (conv_go && armed_q) begin
                    state_d = ST_OVERHEAD;
                    load_en = 1'b1;
                    load_val = start_osc;
                    load_osc = 1'b1;
                end else if (start) begin
                    state_d = ST_PEN_BIAS;
                    load_en = 1'b1;
                    load_val = pen_units;
                end
            end
            ST_PEN_BIAS: begin
                if (wait_zero) begin
                    state_d = ST_PEN_EVAL;
                end
            end
            ST_PEN_EVAL: begin
                if (pen_lvl && job_q != '0
                        && mode_q != TOUCH_WATCH_MODE) begin
                    state_d = ST_OVERHEAD;
                    load_en = 1'b1;
                    load_val = start_osc;
                    load_osc = 1'b1;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_OVERHEAD: begin
                if (wait_zero) begin
                    state_d = ST_CH_BIAS;
                    load_en = 1'b1;
                    load_val = bias_units;
                end
            end
            ST_CH_BIAS: begin
                if (wait_zero) begin
                    state_d = ST_CH_SETTLE;
                    load_en = 1'b1;
                    load_val = settle_units;
                end
            end
            ST_CH_SETTLE: begin
                if (wait_zero) begin
                    state_d = ST_CH_CONV;
                    load_en = 1'b1;
                    load_val = sample_osc;
                    load_osc = 1'b1;
                end
            end
            ST_CH_CONV: begin
                if (wait_zero && rest != '0) begin
                    state_d = ST_CH_BIAS;
                    load_en = 1'b1;
                    load_val = bias_units;
                end else if (wait_zero) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            wait_q <= '0;
            use_osc_q <= 1'b0;
            unit_cnt_q <= 4'h0;
            osc_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            osc_prev_q <= pin_lvl[0];
            if (load_en) begin
                wait_q <= load_val;
                use_osc_q <= load_osc;
                unit_cnt_q <= 4'h0;
            end else begin
                unit_cnt_q <= unit_tick ? 4'h0 : unit_cnt_q + 4'h1;
                if (!wait_zero && (use_osc_q ? osc_edge : unit_tick)) begin
                    wait_q <= wait_q - WAIT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            job_q <= '0;
            cur_q <= '0;
            done_q <= '0;
            bias_q <= '0;
            busy_q <= 1'b0;
        end else begin
            if (start) begin
                job_q <= job_start;
                done_q <= '0;
            end else if (ch_end) begin
                job_q <= rest;
                done_q <= done_q | cur_q;
            end
            if (enter_bias) begin
                cur_q <= next_ch;
            end
            if (sel_go) begin
                bias_q <= chan_oh;
            end else if (enter_bias) begin
                bias_q <= next_ch;
            end else if (ch_end) begin
                bias_q <= '0;
            end
            if (state_d == ST_OVERHEAD) begin
                busy_q <= 1'b1;
            end else if (state_q == ST_DONE) begin
                busy_q <= 1'b0;
            end
        end
    end

    // flags: a hardware set wins over a read clear in the same cycle
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pen_flag_q <= 1'b0;
            touch_src_q <= 1'b0;
            release_src_q <= 1'b0;
            unread_q <= '0;
            irq_n_q <= 1'b1;
            pen_bias_q <= 1'b0;
        end else begin
            if (pen_upd) begin
                pen_flag_q <= pen_lvl;
            end
            touch_src_q <= touch_set | (touch_src_q & ~isrc_rd);
            release_src_q <= release_set | (release_src_q & ~isrc_rd);
            unread_q <= (unread_q & ~data_rd_oh)
                | (state_q == ST_DONE ? done_q : '0);
            irq_n_q <= ~|(isrc & imask_q);
            pen_bias_q <= state_d == ST_PEN_BIAS;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= HOST_DRIVEN_MODE;
            rate_q <= `RST_RATE;
            bias_set_q <= `RST_BIAS;
            settle_set_q <= `RST_SETTLE;
            filt_q <= `RST_FILT;
            chmask_q <= CH_NUM'(`RST_CHMASK);
            imask_q <= `RST_IMASK;
            armed_q <= 1'b0;
        end else begin
            if (cmd_wr && cmd.op == OP_HOST_MODE) begin
                mode_q <= HOST_DRIVEN_MODE;
            end else if (cmd_wr && cmd.op == OP_WATCH_MODE) begin
                mode_q <= TOUCH_WATCH_MODE;
            end else if (cmd_wr && cmd.op == OP_TRIG_MODE) begin
                mode_q <= TOUCH_TRIGGERED_MODE;
            end
            if (sel_go) begin
                armed_q <= 1'b1;
            end else if (conv_go || mode_q != HOST_DRIVEN_MODE) begin
                armed_q <= 1'b0;
            end
            if (i_wr && i_addr == `OFF_RATE) rate_q <= i_wdata[15:0];
            if (i_wr && i_addr == `OFF_BIAS) bias_set_q <= i_wdata[15:0];
            if (i_wr && i_addr == `OFF_SETTLE) settle_set_q <= i_wdata[15:0];
            if (i_wr && i_addr == `OFF_FILT) filt_q <= i_wdata[1:0];
            if (i_wr && i_addr == `OFF_CHMASK) chmask_q <= i_wdata[CH_NUM-1:0];
            if (i_wr && i_addr == `OFF_IMASK) imask_q <= i_wdata[3:0];
        end
    end

    // rate tick generator, held idle in host driven mode or at rate zero
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rate_pre_q <= 12'h0;
            rate_cnt_q <= 16'h0;
            tick_q <= 1'b0;
        end else if (!rate_run) begin
            rate_pre_q <= 12'h0;
            rate_cnt_q <= 16'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (rate_pre_q == 12'(`RATE_UNIT_CYC - 1)) begin
                rate_pre_q <= 12'h0;
                if (rate_cnt_q >= rate_q - 16'h1) begin
                    rate_cnt_q <= 16'h0;
                    tick_q <= 1'b1;
                end else begin
                    rate_cnt_q <= rate_cnt_q + 16'h1;
                end
            end else begin
                rate_pre_q <= rate_pre_q + 12'h1;
            end
        end
    end

    logic [31:0] reg_rd;
    always_comb begin
        reg_rd = 32'h0;
        unique case (i_addr)
            `OFF_RATE: reg_rd = {16'h0, rate_q};
            `OFF_BIAS: reg_rd = {16'h0, bias_set_q};
            `OFF_SETTLE: reg_rd = {16'h0, settle_set_q};
            `OFF_FILT: reg_rd = {30'h0, filt_q};
            `OFF_CHMASK: reg_rd = 32'(chmask_q);
            `OFF_IMASK: reg_rd = {28'h0, imask_q};
            `OFF_STATUS: reg_rd = 32'({unread_q, mode_q, pen_flag_q, busy_q});
            `OFF_ISRC: reg_rd = {28'h0, isrc};
            default: reg_rd = 32'h0;
        endcase
    end

    chan_store #(
        .DEPTH(CH_NUM),
        .WIDTH(DATA_W),
        .AW(3)
    ) u_store (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_we(ch_end),
        .i_waddr(oh_index(cur_q)),
        .i_wdata(i_adc_data),
        .i_re(i_rd),
        .i_sel_mem(data_hit),
        .i_raddr(i_addr[4:2]),
        .i_other(reg_rd),
        .o_rdata(o_rdata)
    );

    assign o_bias_ch = bias_q;
    assign o_pen_bias = pen_bias_q;
    assign o_converting = busy_q;
    assign o_irq_n = irq_n_q;
    assign o_mode = mode_q;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    a_host_tick_idle: assert property (
        mode_q == HOST_DRIVEN_MODE && $past(mode_q) == HOST_DRIVEN_MODE
            |-> !tick_q)
        else $error("rate tick while in host driven mode");
    a_host_pen_hold: assert property (
        state_q == ST_PEN_EVAL && mode_q == HOST_DRIVEN_MODE
            |=> $stable(pen_flag_q))
        else $error("touch flag changed in host driven mode");
    a_watch_no_conv: assert property (
        state_q == ST_PEN_EVAL && mode_q == TOUCH_WATCH_MODE
            |=> state_q == ST_IDLE)
        else $error("watch mode went on to a conversion");
    a_watch_irq_wait: assert property (
        state_q == ST_IDLE && mode_q == TOUCH_WATCH_MODE && !irq_n_q
            |=> state_q == ST_IDLE)
        else $error("pen detection started while irq low");
    a_trig_read_wait: assert property (
        state_q == ST_IDLE && mode_q == TOUCH_TRIGGERED_MODE
            && unread_q != '0 |=> state_q == ST_IDLE)
        else $error("triggered run started before data read");
    a_done_unread: assert property (
        state_q == ST_DONE |=> ((unread_q & $past(done_q)) == $past(done_q))
            ##1 (!irq_n_q || !imask_q[`ISRC_CONV] || $past(i_rd)))
        else $error("conversion end did not mark data and irq");
    a_select_no_pen: assert property (
        conv_go && armed_q |=> state_q == ST_OVERHEAD [*1] ##1 !pen_bias_q)
        else $error("pen detection after select");
    a_bias_onehot: assert property (
        state_q inside {ST_CH_BIAS, ST_CH_SETTLE, ST_CH_CONV}
            |-> $onehot(bias_q) && bias_q == cur_q)
        else $error("channel bias wrong during conversion");
endmodule : touch_acquisition_mode_sequencer

// File: rtl/tacq_consts.svh
// register map, field positions, reset values and timing counts
`ifndef TACQ_CONSTS_SVH
`define TACQ_CONSTS_SVH
`define CH_NUM 5
`define DATA_W 12
`define OFF_CMD 8'h00
`define OFF_RATE 8'h04
`define OFF_BIAS 8'h08
`define OFF_SETTLE 8'h0c
`define OFF_FILT 8'h10
`define OFF_CHMASK 8'h14
`define OFF_IMASK 8'h18
`define OFF_STATUS 8'h1c
`define OFF_ISRC 8'h20
`define OFF_CHDATA 8'h40
`define CHDATA_MASK 8'he3
`define SEQ_CODE 3'h7
`define STAT_BUSY 0
`define STAT_PEN 1
`define STAT_MODE 2
`define STAT_UNREAD 4
`define ISRC_CONV 0
`define RST_RATE 16'h0000
`define RST_BIAS 16'h0000
`define RST_SETTLE 16'h0000
`define RST_FILT 2'h0
`define RST_CHMASK 5'h00
`define RST_IMASK 4'h0
`define CLK_PERIOD_NS 40
`define TS_UNIT_NS 500
`define TS_MAX_US 18190
`define UNIT_CYC ((`TS_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RATE_UNIT_US 100
`define RATE_UNIT_CYC ((`RATE_UNIT_US * 1000) / `CLK_PERIOD_NS)
`define CONV_START_OSC 47
`define CONV_SAMPLE_OSC 21
`define PEN_BIAS_SHIFT 3
`endif

// File: rtl/tacq_pkg.sv
// types shared by the touch acquisition sequencer
package tacq_pkg;
    typedef enum logic [1:0] {
        HOST_DRIVEN_MODE = 2'h0,
        TOUCH_WATCH_MODE = 2'h1,
        TOUCH_TRIGGERED_MODE = 2'h2
    } mode_t;
    typedef enum logic [3:0] {
        OP_HOST_MODE = 4'h1,
        OP_WATCH_MODE = 4'h2,
        OP_TRIG_MODE = 4'h3,
        OP_SELECT = 4'h4,
        OP_CONVERT = 4'h5
    } cmd_op_t;
    typedef struct packed {
        cmd_op_t op;
        logic spare;
        logic [2:0] chan;
    } cmd_t;
    typedef struct packed {
        logic release_ev;
        logic touch_ev;
        logic spare;
        logic conv_done;
    } irq_src_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PEN_BIAS = 3'h1,
        ST_PEN_EVAL = 3'h3,
        ST_OVERHEAD = 3'h2,
        ST_CH_BIAS = 3'h6,
        ST_CH_SETTLE = 3'h7,
        ST_CH_CONV = 3'h5,
        ST_DONE = 3'h4
    } state_t;
endpackage : tacq_pkg

// File: rtl/chan_store.sv
// channel data store with registered read port and read data mux
module chan_store #(
    parameter int DEPTH = 5,
    parameter int WIDTH = 12,
    parameter int AW = 3
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic i_re,
    input wire logic i_sel_mem,
    input wire logic [AW-1:0] i_raddr,
    input wire logic [31:0] i_other,
    output logic [31:0] o_rdata
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    wire logic [31:0] mem_word = {{(32 - WIDTH){1'b0}}, mem_q[i_raddr]};
    wire logic [31:0] rd_word = i_sel_mem ? mem_word : i_other;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    // read data stand only in the cycle after the read strobe
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h0;
        end else begin
            o_rdata <= i_re ? rd_word : 32'h0;
        end
    end
endmodule : chan_store

// File: test/panel_model.sv
// panel side model: free running oscillator, pen comparator, converter
module panel_model (
    input wire logic i_touch,
    input wire logic [4:0] i_bias_ch,
    output logic o_osc_clk,
    output logic o_pen_cmp,
    output logic [11:0] o_adc_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_osc_clk = 1'b0;
        forever #160 o_osc_clk = ~o_osc_clk;
    end
    assign o_pen_cmp = i_touch;
    // an unbiased panel gives a value that no channel produces
    assign o_adc_data = (i_bias_ch == 5'h00) ? 12'hfff : {7'h18, i_bias_ch};
endmodule : panel_model

// File: test/touch_acquisition_mode_sequencer_bench.sv
// self-checking bench for the touch acquisition sequencer
`include "tacq_consts.svh"
module touch_acquisition_mode_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tacq_pkg::*;
    logic i_mclk, i_rst, i_wr, i_rd, touch, osc, pen, conv, irq_n, seen, pb;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, rdata;
    logic [11:0] adc;
    logic [4:0] bias;
    mode_t mode;
    int bad_count = 0;
    int checks_done = 0;
    int dur = 0;
    // busy time of one channel: filter 1, settle 1, bias 15, 8 clk/osc
    localparam int T_SEL = (`CONV_START_OSC + 3 * `CONV_SAMPLE_OSC + 1) * 8
        + 20 * `UNIT_CYC;
    touch_acquisition_mode_sequencer dut (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(rdata), .i_osc_clk(osc), .i_pen_cmp(pen),
        .i_adc_data(adc), .o_bias_ch(bias), .o_pen_bias(pb),
        .o_converting(conv), .o_irq_n(irq_n), .o_mode(mode));
    panel_model panel (.i_touch(touch), .i_bias_ch(bias), .o_osc_clk(osc),
        .o_pen_cmp(pen), .o_adc_data(adc));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        chk(rdata, e);
    endtask : rd
    task automatic set_touch(input logic v);
        touch <= v;
        repeat (8) @(posedge i_mclk);
    endtask : set_touch
    // waits for a conversion to start within lim cycles, then to end
    task automatic run_conv(input logic e, input int lim);
        int n;
        n = 0;
        while (conv !== 1'b1 && n < lim) begin
            @(negedge i_mclk);
            n++;
        end
        chk({31'h0, conv}, {31'h0, e});
        if (conv !== e) wrap_up();
        n = 0;
        while (conv !== 1'b0 && n < 4000) begin
            @(negedge i_mclk);
            n++;
        end
        dur = n;
        if (n == 4000) begin
            bad_count++;
            wrap_up();
        end
    endtask : run_conv
    task automatic wait_irq(input logic e, input int lim);
        int n;
        n = 0;
        while (irq_n !== e && n < lim) begin
            @(negedge i_mclk);
            n++;
        end
        chk({31'h0, irq_n}, {31'h0, e});
        if (irq_n !== e) wrap_up();
    endtask : wait_irq
    // measures how long pen detection biases the panel, in cycles
    task automatic pen_len(input int e);
        int n;
        n = 0;
        @(negedge i_mclk);
        while (pb !== 1'b1 && n < 300) begin
            @(negedge i_mclk);
            n++;
        end
        n = 0;
        while (pb === 1'b1 && n < 300) begin
            @(negedge i_mclk);
            n++;
        end
        chk(n, e);
    endtask : pen_len
    // no conversion may start during the given number of cycles
    task automatic quiet(input int cyc);
        seen = 1'b0;
        repeat (cyc) begin
            @(negedge i_mclk);
            if (conv !== 1'b0) seen = 1'b1;
        end
        chk({31'h0, seen}, 32'h0);
    endtask : quiet
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    initial begin
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        touch = 1'b0;
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        chk({30'h0, mode}, 32'h0);
        rd(`OFF_STATUS, 32'h0);
        rd(8'h30, 32'h0);
        $display("end of reset test");
        wr(`OFF_IMASK, 32'h1);
        set_touch(1'b1);
        wr(`OFF_CMD, 32'h51);
        run_conv(1'b1, 300);
        wait_irq(1'b0, 10);
        rd(`OFF_STATUS, 32'h20);
        rd(`OFF_CHDATA + 8'h04, 32'h302);
        wait_irq(1'b1, 4);
        set_touch(1'b0);
        wr(`OFF_BIAS, 32'hf);
        wr(`OFF_CMD, 32'h51);
        pen_len(2 * `UNIT_CYC + 1);
        run_conv(1'b0, 300);
        rd(`OFF_STATUS, 32'h0);
        $display("end of single convert test");
        wr(`OFF_FILT, 32'h1);
        wr(`OFF_SETTLE, 32'h1);
        wr(`OFF_CMD, 32'h42);
        repeat (4) @(negedge i_mclk);
        chk({27'h0, bias}, 32'h4);
        wr(`OFF_CMD, 32'h52);
        run_conv(1'b1, 300);
        chk({31'h0, dur >= T_SEL - 10 && dur <= T_SEL + 10}, 32'h1);
        rd(`OFF_CHDATA + 8'h08, 32'h304);
        wr(`OFF_FILT, 32'h0);
        $display("end of select test");
        set_touch(1'b1);
        wr(`OFF_CHMASK, 32'h1f);
        wr(`OFF_CMD, 32'h57);
        run_conv(1'b1, 300);
        rd(`OFF_STATUS, 32'h1f0);
        for (int c = 0; c < 5; c++) begin
            rd(`OFF_CHDATA + 8'(4 * c), 32'h300 | (32'h1 << c));
        end
        wait_irq(1'b1, 4);
        $display("end of sequence test");
        set_touch(1'b0);
        wr(`OFF_IMASK, 32'hc);
        wr(`OFF_RATE, 32'h1);
        wr(`OFF_CMD, 32'h20);
        @(negedge i_mclk);
        chk({30'h0, mode}, 32'h1);
        set_touch(1'b1);
        wait_irq(1'b0, 300);
        rd(`OFF_STATUS, 32'h6);
        rd(`OFF_ISRC, 32'h4);
        wait_irq(1'b1, 4);
        quiet(3000);
        set_touch(1'b0);
        wait_irq(1'b0, 3000);
        rd(`OFF_ISRC, 32'h8);
        wr(`OFF_CMD, 32'h10);
        wr(`OFF_RATE, 32'h0);
        @(negedge i_mclk);
        chk({30'h0, mode}, 32'h0);
        set_touch(1'b1);
        quiet(3000);
        $display("end of watch mode test");
        wr(`OFF_CHMASK, 32'h1);
        wr(`OFF_IMASK, 32'h1);
        wr(`OFF_RATE, 32'h1);
        wr(`OFF_CMD, 32'h30);
        run_conv(1'b1, 300);
        wait_irq(1'b0, 10);
        quiet(5200);
        rd(`OFF_CHDATA, 32'h301);
        run_conv(1'b1, 2700);
        wr(`OFF_CMD, 32'h10);
        wr(`OFF_RATE, 32'h0);
        $display("end of triggered mode test");
        wrap_up();
    end
endmodule : touch_acquisition_mode_sequencer_bench
